// ---- rtl/fpd_fan_ctrl.sv ----
// Operation
// - Separate remote and local start thresholds, reset zero.
// - Hysteresis bit selects 5 or 10 degrees.
// - Step bit selects 1 or 2 degrees.
// - Source bits choose remote or local temperature.
// - Both sources set: larger computed duty wins.
// - No source bits: written target sets duty.
// - Manual target ignores maximum, clipped to 240.
// - Rate field sets interval; each step 2/240.
// - Code 001 is 0.0625 s, doubling upward.
// - Rate code 000 applies changes instantly.
// - Ramping stays active in manual mode.
// - Ramp rate register resets to a0h.
// - Step field n gives 2n/240; reset 50h.
// - Frequency selects give 20/33/50/100 Hz, 35k.
// - Frequency register resets to 40h, 33 Hz.
// - Highest frequency coarsens duty to 4/240.
// - Start from rest forces output full 2 s.
// - Spin-up disabled: jump straight to nominal duty.
// - Polarity bit sets full-duty output level.
// - Above threshold add one duty step per step.
// - Below threshold zero or start duty per bit.
// - Automatic duty limited by maximum-duty register.
`include "fpd_params.svh"

module fpd_fan_ctrl import fpd_pkg::*; #(
	parameter int RATE_BASE_CYC = `FPD_RATE_BASE_US * `FPD_CLK_MHZ,
	parameter int SPINUP_CYC    = `FPD_SPINUP_MS * 1000 * `FPD_CLK_MHZ,
	parameter int SLOT_20       = (`FPD_CLK_MHZ * 1000000) / (`FPD_FREQ_20_HZ * `FPD_SLOTS),
	parameter int SLOT_33       = (`FPD_CLK_MHZ * 1000000) / (`FPD_FREQ_33_HZ * `FPD_SLOTS),
	parameter int SLOT_50       = (`FPD_CLK_MHZ * 1000000) / (`FPD_FREQ_50_HZ * `FPD_SLOTS),
	parameter int SLOT_100      = (`FPD_CLK_MHZ * 1000000) / (`FPD_FREQ_100_HZ * `FPD_SLOTS),
	parameter int SLOT_35K      = (`FPD_CLK_MHZ * 1000000) / (`FPD_FREQ_35K_HZ * `FPD_SLOTS)
) (
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Register port.
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic [7:0]      reg_rdata_o,
	// Temperature readings from the converter.
	input  wire logic [7:0] remote_temp_i,
	input  wire logic [7:0] local_temp_i,
	input  wire logic       temp_valid_i,
	// Open-drain fan drive pin.
	output logic            fan_drive_output_o,
	output logic            fan_drive_output_oe_o
);

	fpd_duty_t   cfg, start_duty, max_duty, target, inst, man_target;
	logic [7:0]  start_temp [2];
	logic [7:0]  fan_cfg, ramp_rate, step_size, freq_sel;
	logic [7:0]  held_temp [2];
	logic [7:0]  peak_temp [2];
	logic        active [2];
	fpd_state_t  state;
	logic [31:0] tick_cnt;
	logic [7:0]  rdata;

	fpd_duty_t   next_cfg, next_start_duty, next_max_duty, next_target, next_inst, next_man_target;
	logic [7:0]  next_start_temp [2];
	logic [7:0]  next_fan_cfg, next_ramp_rate, next_step_size, next_freq_sel;
	logic [7:0]  next_held_temp [2];
	logic [7:0]  next_peak_temp [2];
	logic        next_active [2];
	fpd_state_t  next_state;
	logic [31:0] next_tick_cnt;
	logic [7:0]  next_rdata;

	logic [7:0]  cur_temp [2];
	fpd_duty_t   chan_duty [2];
	fpd_duty_t   auto_duty;
	logic [7:0]  hyst;
	logic        manual;
	logic [2:0]  rate_code;
	logic [31:0] interval;
	logic        pwm_level;

	// Clip any duty value to full scale.
	function automatic fpd_duty_t fpd_clip(input logic [7:0] v);
		return (v > `FPD_FULL_DUTY) ? `FPD_FULL_DUTY : v;
	endfunction : fpd_clip

	// Duty for one channel from its held temperature and threshold.
	function automatic fpd_duty_t fpd_calc(input logic [7:0] t, input logic [7:0] fst,
			input logic act, input logic [7:0] fsdc, input logic [7:0] dmax,
			input logic [3:0] n, input logic tstep2, input logic min_duty);
		logic [7:0]  diff;
		logic [7:0]  steps;
		logic [13:0] dc;
		diff  = (t > fst) ? t - fst : 8'h00;
		steps = tstep2 ? {1'b0, diff[7:1]} : diff;
		dc    = 14'(fpd_clip(fsdc)) + 14'(steps) * 14'({n, 1'b0});
		if (!act) begin
			dc = min_duty ? 14'(fpd_clip(fsdc)) : 14'h0;
		end
		if (dc > 14'(fpd_clip(dmax))) begin
			dc = 14'(fpd_clip(dmax));
		end
		return {dc[7:1], 1'b0};
	endfunction : fpd_calc

	// Mode, hysteresis and interval decode.
	always_comb begin
		cur_temp[0] = remote_temp_i;
		cur_temp[1] = local_temp_i;
		hyst        = fan_cfg[`FPD_FAN_HYST] ? `FPD_HYST_HI_C : `FPD_HYST_LO_C;
		manual      = !fan_cfg[`FPD_FAN_REMOTE] && !fan_cfg[`FPD_FAN_LOCAL];
		rate_code   = ramp_rate[`FPD_RATE_MSB:`FPD_RATE_LSB];
		interval    = 32'(RATE_BASE_CYC) << ((rate_code == 3'h0) ? 3'h0 : rate_code - 3'h1);
		for (int i = 0; i < 2; i++) begin
			chan_duty[i] = fpd_calc(held_temp[i], start_temp[i], active[i], start_duty, max_duty,
				step_size[`FPD_STEP_MSB:`FPD_STEP_LSB], fan_cfg[`FPD_FAN_TSTEP], cfg[`FPD_CFG_MIN_DUTY]);
		end
		auto_duty = 8'h00;
		if (fan_cfg[`FPD_FAN_REMOTE]) begin
			auto_duty = chan_duty[0];
		end
		if (fan_cfg[`FPD_FAN_LOCAL] && chan_duty[1] > auto_duty) begin
			auto_duty = chan_duty[1];
		end
	end

	// Register writes and read data.
	always_comb begin
		next_cfg           = cfg;
		next_start_duty    = start_duty;
		next_max_duty      = max_duty;
		next_man_target    = man_target;
		next_start_temp[0] = start_temp[0];
		next_start_temp[1] = start_temp[1];
		next_fan_cfg       = fan_cfg;
		next_ramp_rate     = ramp_rate;
		next_step_size     = step_size;
		next_freq_sel      = freq_sel;
		next_rdata         = rdata;
		if (reg_wr_i) begin
			if (reg_addr_i == `FPD_OFS_CONFIG) begin
				next_cfg = reg_wdata_i;
			end else if (reg_addr_i == `FPD_OFS_START_DUTY) begin
				next_start_duty = reg_wdata_i;
			end else if (reg_addr_i == `FPD_OFS_MAX_DUTY) begin
				next_max_duty = reg_wdata_i;
			end else if (reg_addr_i == `FPD_OFS_TARGET) begin
				next_man_target = fpd_clip(reg_wdata_i);
			end else if (reg_addr_i == `FPD_OFS_REMOTE_START) begin
				next_start_temp[0] = reg_wdata_i;
			end else if (reg_addr_i == `FPD_OFS_LOCAL_START) begin
				next_start_temp[1] = reg_wdata_i;
			end else if (reg_addr_i == `FPD_OFS_FAN_CFG) begin
				next_fan_cfg = reg_wdata_i;
			end else if (reg_addr_i == `FPD_OFS_RAMP_RATE) begin
				next_ramp_rate = reg_wdata_i;
			end else if (reg_addr_i == `FPD_OFS_STEP_SIZE) begin
				next_step_size = reg_wdata_i;
			end else if (reg_addr_i == `FPD_OFS_FREQ_SEL) begin
				next_freq_sel = reg_wdata_i;
			end
		end
		// Unmapped addresses read as zero.
		if (reg_rd_i) begin
			if (reg_addr_i == `FPD_OFS_CONFIG) begin
				next_rdata = cfg;
			end else if (reg_addr_i == `FPD_OFS_START_DUTY) begin
				next_rdata = start_duty;
			end else if (reg_addr_i == `FPD_OFS_MAX_DUTY) begin
				next_rdata = max_duty;
			end else if (reg_addr_i == `FPD_OFS_TARGET) begin
				next_rdata = target;
			end else if (reg_addr_i == `FPD_OFS_INST) begin
				next_rdata = inst;
			end else if (reg_addr_i == `FPD_OFS_REMOTE_START) begin
				next_rdata = start_temp[0];
			end else if (reg_addr_i == `FPD_OFS_LOCAL_START) begin
				next_rdata = start_temp[1];
			end else if (reg_addr_i == `FPD_OFS_FAN_CFG) begin
				next_rdata = fan_cfg;
			end else if (reg_addr_i == `FPD_OFS_RAMP_RATE) begin
				next_rdata = ramp_rate;
			end else if (reg_addr_i == `FPD_OFS_STEP_SIZE) begin
				next_rdata = step_size;
			end else if (reg_addr_i == `FPD_OFS_FREQ_SEL) begin
				next_rdata = freq_sel;
			end else begin
				next_rdata = 8'h00;
			end
		end
	end

	// Per channel, a falling reading is ignored until it drops a full
	// hysteresis below the last peak, so the fan does not hunt.
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_held_temp[i] = held_temp[i];
			next_peak_temp[i] = peak_temp[i];
			next_active[i]    = active[i];
			if (temp_valid_i) begin
				if (cur_temp[i] > peak_temp[i] || 9'(cur_temp[i]) + 9'(hyst) <= 9'(peak_temp[i])) begin
					next_held_temp[i] = cur_temp[i];
					next_peak_temp[i] = cur_temp[i];
				end
				if (cur_temp[i] >= start_temp[i]) begin
					next_active[i] = 1'b1;
				end else if (9'(cur_temp[i]) + 9'(hyst) < 9'(start_temp[i])) begin
					next_active[i] = 1'b0;
				end
			end
		end
	end

	// Target selection, spin-up and rate-limited approach.
	always_comb begin
		next_target   = manual ? man_target : auto_duty;
		next_inst     = inst;
		next_state    = state;
		next_tick_cnt = tick_cnt + 32'h1;
		case (state)
			FPD_ST_RUN: begin
				if (inst == 8'h00 && target != 8'h00) begin
					next_tick_cnt = 32'h0;
					if (cfg[`FPD_CFG_SPIN_DIS]) begin
						next_inst = target;
					end else begin
						next_state = FPD_ST_SPIN;
					end
				end else if (inst == target) begin
					next_tick_cnt = 32'h0;
				end else if (rate_code == 3'h0) begin
					next_inst     = target;
					next_tick_cnt = 32'h0;
				end else if (tick_cnt >= interval - 32'h1) begin
					next_tick_cnt = 32'h0;
					if (target > inst) begin
						next_inst = (target - inst < `FPD_DUTY_INC) ? target : inst + `FPD_DUTY_INC;
					end else begin
						next_inst = (inst - target < `FPD_DUTY_INC) ? target : inst - `FPD_DUTY_INC;
					end
				end
			end
			FPD_ST_SPIN: begin
				if (target == 8'h00) begin
					next_state    = FPD_ST_RUN;
					next_tick_cnt = 32'h0;
				end else if (tick_cnt >= 32'(SPINUP_CYC) - 32'h1) begin
					next_state    = FPD_ST_RUN;
					next_inst     = target;
					next_tick_cnt = 32'h0;
				end
			end
			default: begin
				next_state    = FPD_ST_RUN;
				next_tick_cnt = 32'h0;
			end
		endcase
	end

	// State registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg           <= `FPD_RST_CONFIG;
			start_duty    <= `FPD_RST_START_DUTY;
			max_duty      <= `FPD_RST_MAX_DUTY;
			man_target    <= `FPD_RST_TARGET;
			target        <= `FPD_RST_TARGET;
			inst          <= 8'h00;
			start_temp[0] <= `FPD_RST_START_TEMP;
			start_temp[1] <= `FPD_RST_START_TEMP;
			fan_cfg       <= `FPD_RST_FAN_CFG;
			ramp_rate     <= `FPD_RST_RAMP_RATE;
			step_size     <= `FPD_RST_STEP_SIZE;
			freq_sel      <= `FPD_RST_FREQ_SEL;
			held_temp[0]  <= 8'h00;
			held_temp[1]  <= 8'h00;
			peak_temp[0]  <= 8'h00;
			peak_temp[1]  <= 8'h00;
			active[0]     <= 1'b0;
			active[1]     <= 1'b0;
			state         <= FPD_ST_RUN;
			tick_cnt      <= 32'h0;
			rdata         <= 8'h00;
		end else begin
			cfg           <= next_cfg;
			start_duty    <= next_start_duty;
			max_duty      <= next_max_duty;
			man_target    <= next_man_target;
			target        <= next_target;
			inst          <= next_inst;
			start_temp[0] <= next_start_temp[0];
			start_temp[1] <= next_start_temp[1];
			fan_cfg       <= next_fan_cfg;
			ramp_rate     <= next_ramp_rate;
			step_size     <= next_step_size;
			freq_sel      <= next_freq_sel;
			held_temp[0]  <= next_held_temp[0];
			held_temp[1]  <= next_held_temp[1];
			peak_temp[0]  <= next_peak_temp[0];
			peak_temp[1]  <= next_peak_temp[1];
			active[0]     <= next_active[0];
			active[1]     <= next_active[1];
			state         <= next_state;
			tick_cnt      <= next_tick_cnt;
			rdata         <= next_rdata;
		end
	end

	// Output waveform; select bits pass in their own order, so index 0 (bit 5) is select C.
	fpd_pwm_gen #(
		.SLOT_20  (SLOT_20),
		.SLOT_33  (SLOT_33),
		.SLOT_50  (SLOT_50),
		.SLOT_100 (SLOT_100),
		.SLOT_35K (SLOT_35K)
	) u_pwm (
		.clk_i        (clk_i),
		.rst_i        (rst_i),
		.duty_i       (inst),
		.freq_sel_i   ({freq_sel[`FPD_FREQ_MSB], freq_sel[`FPD_FREQ_MSB-1], freq_sel[`FPD_FREQ_LSB]}),
		.invert_i     (cfg[`FPD_CFG_INVERT]),
		.force_full_i (state == FPD_ST_SPIN),
		.level_o      (pwm_level)
	);

	// The pin only pulls low; high comes from the external pull-up.
	assign fan_drive_output_o    = 1'b0;
	assign fan_drive_output_oe_o = ~pwm_level;
	assign reg_rdata_o           = rdata;

endmodule : fpd_fan_ctrl

// ---- pkg/fpd_params.svh ----
`ifndef FPD_PARAMS_SVH
`define FPD_PARAMS_SVH

// Register offsets on the management port.
`define FPD_OFS_CONFIG       8'h02
`define FPD_OFS_START_DUTY   8'h07
`define FPD_OFS_MAX_DUTY     8'h08
`define FPD_OFS_TARGET       8'h09
`define FPD_OFS_INST         8'h0a
`define FPD_OFS_REMOTE_START 8'h0b
`define FPD_OFS_LOCAL_START  8'h0c
`define FPD_OFS_FAN_CFG      8'h0d
`define FPD_OFS_RAMP_RATE    8'h0e
`define FPD_OFS_STEP_SIZE    8'h0f
`define FPD_OFS_FREQ_SEL     8'h10

// Power-on values.
`define FPD_RST_CONFIG       8'h00
`define FPD_RST_START_DUTY   8'h60
`define FPD_RST_MAX_DUTY     8'hf0
`define FPD_RST_TARGET       8'h00
`define FPD_RST_START_TEMP   8'h00
`define FPD_RST_FAN_CFG      8'h00
`define FPD_RST_RAMP_RATE    8'ha0
`define FPD_RST_STEP_SIZE    8'h50
`define FPD_RST_FREQ_SEL     8'h40

// Field positions.
`define FPD_CFG_INVERT       4
`define FPD_CFG_MIN_DUTY     3
`define FPD_CFG_SPIN_DIS     2
`define FPD_FAN_HYST         7
`define FPD_FAN_TSTEP        6
`define FPD_FAN_REMOTE       5
`define FPD_FAN_LOCAL        4
`define FPD_RATE_MSB         7
`define FPD_RATE_LSB         5
`define FPD_STEP_MSB         7
`define FPD_STEP_LSB         4
`define FPD_FREQ_MSB         7
`define FPD_FREQ_LSB         5

// Duty scale and fan-control figures.
`define FPD_FULL_DUTY        8'hf0
`define FPD_DUTY_INC         8'h02
`define FPD_HYST_LO_C        8'h05
`define FPD_HYST_HI_C        8'h0a
`define FPD_SLOTS            240

// Timing figures and clock rate.
`define FPD_CLK_MHZ          200
`define FPD_RATE_BASE_US     62500
`define FPD_SPINUP_MS        2000
`define FPD_FREQ_20_HZ       20
`define FPD_FREQ_33_HZ       33
`define FPD_FREQ_50_HZ       50
`define FPD_FREQ_100_HZ      100
`define FPD_FREQ_35K_HZ      35000

`endif

// ---- pkg/fpd_pkg.sv ----
package fpd_pkg;

	// Duty values are in 1/240 units of the output period.
	typedef logic [7:0] fpd_duty_t;

	// Duty sequencer: normal running or forced spin-up.
	typedef enum logic [1:0] {
		FPD_ST_RUN  = 2'b00,
		FPD_ST_SPIN = 2'b01
	} fpd_state_t;

endpackage : fpd_pkg

// ---- rtl/fpd_pwm_gen.sv ----
`include "fpd_params.svh"

module fpd_pwm_gen import fpd_pkg::*; #(
	parameter int SLOT_20  = 41666,
	parameter int SLOT_33  = 25252,
	parameter int SLOT_50  = 16666,
	parameter int SLOT_100 = 8333,
	parameter int SLOT_35K = 23
) (
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Control.
	input  wire fpd_duty_t  duty_i,
	input  wire logic [2:0] freq_sel_i,
	input  wire logic       invert_i,
	input  wire logic       force_full_i,
	// Output level.
	output logic            level_o
);

	logic [31:0] slot_cnt, next_slot_cnt;
	logic [7:0]  slot_idx, next_slot_idx;
	fpd_duty_t   duty_q, next_duty_q;
	logic        next_level;
	logic [31:0] slot_len;

	// Slot length per frequency; select C overrides A and B.
	always_comb begin
		if (freq_sel_i[0]) begin
			slot_len = 32'(SLOT_35K);
		end else if (freq_sel_i[2:1] == 2'b00) begin
			slot_len = 32'(SLOT_20);
		end else if (freq_sel_i[2:1] == 2'b01) begin
			slot_len = 32'(SLOT_33);
		end else if (freq_sel_i[2:1] == 2'b10) begin
			slot_len = 32'(SLOT_50);
		end else begin
			slot_len = 32'(SLOT_100);
		end
	end

	// The duty is latched at period start so a change never cuts a pulse short.
	always_comb begin
		next_slot_cnt = slot_cnt + 32'h1;
		next_slot_idx = slot_idx;
		next_duty_q   = duty_q;
		if (slot_cnt >= slot_len - 32'h1) begin
			next_slot_cnt = 32'h0;
			next_slot_idx = slot_idx + 8'h01;
			if (slot_idx == 8'(`FPD_SLOTS - 1)) begin
				next_slot_idx = 8'h00;
				next_duty_q   = freq_sel_i[0] ? (duty_i & 8'hfc) : duty_i;
			end
		end
		// Full duty drives low unless inverted.
		next_level = ((slot_idx < duty_q) || force_full_i) ? invert_i : ~invert_i;
	end

	// Period counters and output level.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slot_cnt <= 32'h0;
			slot_idx <= 8'h00;
			duty_q   <= 8'h00;
			level_o  <= 1'b1;
		end else begin
			slot_cnt <= next_slot_cnt;
			slot_idx <= next_slot_idx;
			duty_q   <= next_duty_q;
			level_o  <= next_level;
		end
	end

endmodule : fpd_pwm_gen

// ---- testbench/fpd_fan_model.sv ----
module fpd_fan_model (
	// Clock.
	input  wire logic clk_i,
	// Drive from the controller.
	input  wire logic oe_i,
	// Pin level and running count of low cycles.
	output logic      pin_o,
	output int        low_cnt_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// The pin has a pull-up, so a released driver always reads high, never a stale level.
	assign pin_o = oe_i ? 1'b0 : 1'b1;

	// The count only grows; the bench takes differences, so it needs no clear.
	initial low_cnt_o = 0;
	always @(posedge clk_i) begin
		low_cnt_o <= low_cnt_o + (pin_o ? 0 : 1);
	end
endmodule : fpd_fan_model

// ---- testbench/fpd_fan_ctrl_sva.sv ----
module fpd_fan_ctrl_chk (
	// Clock and reset.
	input wire logic       clk_i,
	input wire logic       rst_i,
	// Register port.
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Fan pin.
	input wire logic       fan_drive_output_o,
	input wire logic       fan_drive_output_oe_o
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [1:0] src;
	logic       touched;

	// Shadow the source bits and note the first write, so power-on reads can be judged.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src     <= 2'b00;
			touched <= 1'b0;
		end else begin
			if (reg_wr_i && reg_addr_i == 8'h0d) begin
				src <= reg_wdata_i[5:4];
			end
			if (reg_wr_i) begin
				touched <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_release; $past(rst_i) |-> !fan_drive_output_oe_o; endproperty
	a_release: assert property (p_release) else $error("pin not released after reset");
	property p_od_data; fan_drive_output_o == 1'b0; endproperty
	a_od_data: assert property (p_od_data) else $error("open-drain data not low");
	property p_rate_por; reg_rd_i && !touched && reg_addr_i == 8'h0e |=> reg_rdata_o == 8'ha0; endproperty
	a_rate_por: assert property (p_rate_por) else $error("ramp rate power-on value");
	property p_step_por; reg_rd_i && !touched && reg_addr_i == 8'h0f |=> reg_rdata_o == 8'h50; endproperty
	a_step_por: assert property (p_step_por) else $error("step size power-on value");
	property p_freq_por; reg_rd_i && !touched && reg_addr_i == 8'h10 |=> reg_rdata_o == 8'h40; endproperty
	a_freq_por: assert property (p_freq_por) else $error("frequency power-on value");
	property p_start_por;
		reg_rd_i && !touched && reg_addr_i inside {8'h0b, 8'h0c} |=> reg_rdata_o == 8'h00;
	endproperty
	a_start_por: assert property (p_start_por) else $error("start threshold power-on value");
	property p_readback;
		(reg_wr_i && reg_addr_i inside {[8'h0b:8'h10]}) ##1 !reg_wr_i ##1
		(reg_rd_i && !reg_wr_i && reg_addr_i == $past(reg_addr_i, 2)) |=> reg_rdata_o == $past(reg_wdata_i, 3);
	endproperty
	a_readback: assert property (p_readback) else $error("register read-back differs");
	property p_clip;
		(reg_wr_i && reg_addr_i == 8'h09 && src == 2'b00) ##1 !reg_wr_i ##1 (reg_rd_i && reg_addr_i == 8'h09)
		|=> reg_rdata_o == (($past(reg_wdata_i, 3) > 8'hf0) ? 8'hf0 : $past(reg_wdata_i, 3));
	endproperty
	a_clip: assert property (p_clip) else $error("manual target not clipped");
	property p_rd_hold; !reg_rd_i |=> $stable(reg_rdata_o); endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
endmodule : fpd_fan_ctrl_chk

bind fpd_fan_ctrl fpd_fan_ctrl_chk chk_u (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
	.fan_drive_output_o(fan_drive_output_o), .fan_drive_output_oe_o(fan_drive_output_oe_o));

// ---- testbench/fpd_fan_ctrl_bench.sv ----
`define CHK(nm, ex, got) \
	begin \
		samples_checked++; \
		if ((got) !== (ex)) begin \
			mismatches++; \
			$display("BAD %s exp %0h got %0h", nm, ex, got); \
		end \
	end

module fpd_fan_ctrl_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// Shortened counts keep the run brief; expectations derive from these.
	localparam int             BASE   = 8;
	localparam int             SPIN   = 50;
	localparam logic [7:0]     RA [11] = '{8'h02, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10};
	localparam logic [7:0]     RV [11] = '{8'h00, 8'h60, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha0, 8'h50, 8'h40};
	localparam int             SL [6]  = '{6, 5, 4, 3, 2, 2};
	localparam logic [7:0]     FS [6]  = '{8'h00, 8'h40, 8'h80, 8'hc0, 8'h20, 8'he0};
	logic       clk_i, rst_i, reg_wr_i, reg_rd_i, temp_valid_i, drv_o, drv_oe, pin;
	logic [7:0] reg_addr_i, reg_wdata_i, remote_temp_i, local_temp_i, rdata;
	int         low_cnt, mismatches, samples_checked, cycles;

	fpd_fan_ctrl #(.RATE_BASE_CYC(BASE), .SPINUP_CYC(SPIN), .SLOT_20(6), .SLOT_33(5), .SLOT_50(4),
		.SLOT_100(3), .SLOT_35K(2)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(rdata),
		.remote_temp_i(remote_temp_i), .local_temp_i(local_temp_i), .temp_valid_i(temp_valid_i),
		.fan_drive_output_o(drv_o), .fan_drive_output_oe_o(drv_oe));
	fpd_fan_model fan_u (.clk_i(clk_i), .oe_i(drv_oe), .pin_o(pin), .low_cnt_o(low_cnt));

	// Clock at 200 MHz.
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end

	// A hung wait ends the run as a failure rather than spinning forever.
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr

	// Read data lands at the taking edge, so it is sampled just after it.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1 d = rdata;
	endtask : rd

	task automatic expect_reg(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		rd(a, d);
		`CHK($sformatf("reg_%h", a), e, d)
	endtask : expect_reg

	task automatic temp(input logic [7:0] r, input logic [7:0] l);
		@(posedge clk_i);
		remote_temp_i <= r;
		local_temp_i <= l;
		temp_valid_i <= 1'b1;
		@(posedge clk_i);
		temp_valid_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask : temp

	task automatic low_over(input int n, output int cnt);
		int c0;
		@(posedge clk_i);
		#1 c0 = low_cnt;
		repeat (n) @(posedge clk_i);
		#1 cnt = low_cnt - c0;
	endtask : low_over

	task automatic t_reset;
		for (int i = 0; i < 11; i++) expect_reg(RA[i], RV[i]);
		wr(8'h0a, 8'h55);
		expect_reg(8'h0a, 8'h00);
		expect_reg(8'h20, 8'h00);
		wr(8'h0f, 8'h35);
		expect_reg(8'h0f, 8'h35);
	endtask : t_reset

	// A start from rest holds the pin at full drive while the applied duty stays zero.
	task automatic t_spin;
		int n;
		wr(8'h0e, 8'h20);
		wr(8'h09, 8'h10);
		repeat (5) @(posedge clk_i);
		low_over(30, n);
		`CHK("spin_low", 30, n)
		expect_reg(8'h0a, 8'h00);
		repeat (30) @(posedge clk_i);
		expect_reg(8'h0a, 8'h10);
		wr(8'h09, 8'hff);
		expect_reg(8'h09, 8'hf0);
	endtask : t_spin

	// The gap is timed between two later steps, since the first step after a rate write may be partial.
	task automatic t_ramp;
		logic [7:0] a, b;
		time        t0;
		for (int c = 1; c < 4; c++) begin
			wr(8'h0e, 8'(c << 5));
			rd(8'h0a, a);
			b = a;
			for (int k = 0; k < 100 && b === a; k++) rd(8'h0a, b);
			t0 = $time;
			a = b;
			for (int k = 0; k < 100 && b === a; k++) rd(8'h0a, b);
			`CHK("ramp_gap", BASE << (c - 1), int'(($time - t0) / 5))
			`CHK("ramp_inc", a + 8'h02, b)
		end
		wr(8'h0e, 8'h20);
		wr(8'h09, 8'h30);
		repeat (400) @(posedge clk_i);
		expect_reg(8'h0a, 8'h30);
		// A falling ramp must stop on an odd target, not step past it.
		wr(8'h09, 8'h2b);
		repeat (60) @(posedge clk_i);
		expect_reg(8'h0a, 8'h2b);
		wr(8'h0e, 8'h00);
		wr(8'h09, 8'h80);
		// The applied duty follows the target register one cycle later.
		@(posedge clk_i);
		expect_reg(8'h0a, 8'h80);
	endtask : t_ramp

	task automatic t_spin_dis;
		wr(8'h09, 8'h00);
		wr(8'h02, 8'h04);
		wr(8'h0e, 8'ha0);
		wr(8'h09, 8'h60);
		// One cycle for the target, then the jump; a spin-up would hold zero far longer.
		@(posedge clk_i);
		expect_reg(8'h0a, 8'h60);
		wr(8'h02, 8'h00);
		wr(8'h0e, 8'h00);
	endtask : t_spin_dis

	// One whole period is counted after two settling periods, so the phase does not matter.
	task automatic t_pwm;
		int n, on;
		wr(8'h09, 8'h76);
		for (int inv = 0; inv < 2; inv++) begin
			wr(8'h02, inv ? 8'h10 : 8'h00);
			for (int i = 0; i < 6; i++) begin
				wr(8'h10, FS[i]);
				repeat (480 * SL[i]) @(posedge clk_i);
				low_over(240 * SL[i], n);
				on = (FS[i][5] ? 116 : 118) * SL[i];
				`CHK("pwm_low", inv ? 240 * SL[i] - on : on, n)
			end
		end
		wr(8'h02, 8'h00);
	endtask : t_pwm

	task automatic t_auto;
		wr(8'h07, 8'h20);
		wr(8'h0b, 8'h28);
		wr(8'h0c, 8'h28);
		wr(8'h0f, 8'h20);
		wr(8'h0d, 8'h20);
		temp(8'h32, 8'h14);
		expect_reg(8'h09, 8'h48);
		wr(8'h0d, 8'h10);
		temp(8'h32, 8'h37);
		expect_reg(8'h09, 8'h5c);
		wr(8'h0d, 8'h30);
		temp(8'h34, 8'h3c);
		expect_reg(8'h09, 8'h70);
		wr(8'h0d, 8'h70);
		temp(8'h34, 8'h3e);
		expect_reg(8'h09, 8'h4c);
		wr(8'h08, 8'h40);
		temp(8'h34, 8'h3f);
		expect_reg(8'h09, 8'h40);
		wr(8'h08, 8'hf0);
		wr(8'h0d, 8'h30);
		temp(8'h14, 8'h14);
		expect_reg(8'h09, 8'h00);
		wr(8'h02, 8'h08);
		temp(8'h15, 8'h15);
		expect_reg(8'h09, 8'h20);
		temp(8'h2d, 8'h2d);
		expect_reg(8'h09, 8'h34);
		temp(8'h29, 8'h29);
		expect_reg(8'h09, 8'h34);
		wr(8'h0d, 8'hb0);
		temp(8'h24, 8'h24);
		expect_reg(8'h09, 8'h34);
	endtask : t_auto

	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : conclude

	// Main sequence: reset for five cycles, then each scenario in turn.
	initial begin
		{rst_i, reg_wr_i, reg_rd_i, temp_valid_i} = 4'b1000;
		{reg_addr_i, reg_wdata_i, remote_temp_i, local_temp_i} = 32'h0;
		{mismatches, samples_checked, cycles} = '0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_spin();
		t_ramp();
		t_spin_dis();
		t_pwm();
		t_auto();
		conclude();
	end
endmodule : fpd_fan_ctrl_bench
